/* pkg/rtcc_defs.svh */
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
// Overview of operation
// - century enable D7, flag D6, address 03h
// - enable set: flag inverts at century turn
// - enable clear: flag holds at century turn
// - no function active: pin follows level bit
// - level and test bits clear, watchdog zero, alarm interrupt off: pin low
// - pin is open drain, pulls low only
// - initial power-up clears watchdog, enables, test
// - initial power-up sets halt, level, marker
// - backup power-up sets marker, clears test, watchdog
// - other bits undefined after initial power-up
// - watchdog prevails over frequency test output
// - frequency test toggles pin at 512 Hz
// - enabled alarm drives pin as interrupt while square wave is disabled
`define RTCC_HOURS_ADDR     8'h03
`define RTCC_YEAR_LAST      8'h99
`define RTCC_CTRL_ADDR      8'h08
`define RTCC_CEN_BIT        7
`define RTCC_CFLAG_BIT      6
`define RTCC_LEVEL_BIT      7
`define RTCC_FTEST_BIT      6
`define RTCC_WDOG_W         7
`define RTCC_WDOG_ZERO      7'h00
`define RTCC_CLK_HZ         50000000
`define RTCC_FTEST_HZ       512
`define RTCC_HALF_CYC       (`RTCC_CLK_HZ / (2 * `RTCC_FTEST_HZ))
`define RTCC_CNT_W          16
`endif

/* pkg/rtcc_pkg.sv */
package rtcc_pkg;
    // power-up event selected on first clock after reset release
    typedef enum logic [1:0] {
        RTCC_PWR_RUN     = 2'b00,
        RTCC_PWR_INITIAL = 2'b01,
        RTCC_PWR_BACKUP  = 2'b11
    } rtcc_pwr_type;
    // pin source, gray along usual path
    typedef enum logic [1:0] {
        RTCC_SRC_LEVEL = 2'b00,
        RTCC_SRC_FTEST = 2'b01,
        RTCC_SRC_WDOG  = 2'b11,
        RTCC_SRC_IRQ   = 2'b10
    } rtcc_src_type;
endpackage : rtcc_pkg

/* pkg/rtcc_pin_if.sv */
`timescale 1ns/10ps
interface rtcc_pin_if;
    logic level_bit;
    logic ftest_bit;
    logic alarm_irq_enable;
    logic square_wave_enable;
    logic alarm_flag;
    logic wdog_nonzero;
    logic wdog_fired;
    logic osc_running;
    logic pull_low;
    modport ctrl (output level_bit, ftest_bit, alarm_irq_enable, square_wave_enable,
                  alarm_flag, wdog_nonzero, wdog_fired, osc_running, input pull_low);
    modport pin  (input level_bit, ftest_bit, alarm_irq_enable, square_wave_enable,
                  alarm_flag, wdog_nonzero, wdog_fired, osc_running, output pull_low);
endinterface : rtcc_pin_if

/* logic/rtcc_pin_mux.sv */
`timescale 1ns/10ps
`include "rtcc_defs.svh"
module rtcc_pin_mux #(
    parameter int HALF_CYC = `RTCC_HALF_CYC
) (
    input  wire logic  clock,
    input  wire logic  resetn,
    rtcc_pin_if.pin    pif
);
    logic [`RTCC_CNT_W-1:0] div_reg;
    logic                   tog_reg;
    logic                   low_reg;
    rtcc_pkg::rtcc_src_type src;

    // 512 Hz test divider
    always_ff @(posedge clock) begin
        if (!resetn || !pif.osc_running) begin
            div_reg <= '0;
            tog_reg <= 1'b0;
        end else if (div_reg == `RTCC_CNT_W'(HALF_CYC - 1)) begin
            div_reg <= '0;
            tog_reg <= ~tog_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // source priority: alarm, watchdog, test, level
    always_comb begin
        if (pif.alarm_irq_enable && !pif.square_wave_enable)
            src = rtcc_pkg::RTCC_SRC_IRQ;
        else if (pif.wdog_nonzero)
            src = rtcc_pkg::RTCC_SRC_WDOG;
        else if (pif.ftest_bit && !pif.square_wave_enable)
            src = rtcc_pkg::RTCC_SRC_FTEST;
        else
            src = rtcc_pkg::RTCC_SRC_LEVEL;
    end

    // registered pull-low request
    always_ff @(posedge clock) begin
        if (!resetn) begin
            low_reg <= 1'b0;
        end else begin
            case (src)
                rtcc_pkg::RTCC_SRC_IRQ:   low_reg <= pif.alarm_flag;
                rtcc_pkg::RTCC_SRC_WDOG:  low_reg <= pif.wdog_fired;
                rtcc_pkg::RTCC_SRC_FTEST: low_reg <= ~tog_reg;
                rtcc_pkg::RTCC_SRC_LEVEL: low_reg <= ~pif.level_bit;
                default:                  low_reg <= ~pif.level_bit;
            endcase
        end
    end
    assign pif.pull_low = low_reg;

    property p_level_follow;
        @(posedge clock) disable iff (!resetn)
        (src == rtcc_pkg::RTCC_SRC_LEVEL) |=> (low_reg == !$past(pif.level_bit));
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("pin not following level");

    property p_both_zero_low;
        @(posedge clock) disable iff (!resetn)
        (!pif.level_bit && !pif.ftest_bit && !pif.alarm_irq_enable && !pif.wdog_nonzero)
            |=> low_reg;
    endproperty
    a_both_zero_low: assert property (p_both_zero_low) else $error("pin not low");

    property p_wdog_wins;
        @(posedge clock) disable iff (!resetn)
        (pif.wdog_nonzero && pif.ftest_bit && !pif.alarm_irq_enable)
            |=> (low_reg == $past(pif.wdog_fired));
    endproperty
    a_wdog_wins: assert property (p_wdog_wins) else $error("test output not suppressed");

    property p_irq_wins;
        @(posedge clock) disable iff (!resetn)
        (pif.alarm_irq_enable && !pif.square_wave_enable && pif.alarm_flag) |=> low_reg;
    endproperty
    a_irq_wins: assert property (p_irq_wins) else $error("alarm not asserted on pin");

    property p_div_bound;
        @(posedge clock) disable iff (!resetn)
        div_reg < `RTCC_CNT_W'(HALF_CYC);
    endproperty
    a_div_bound: assert property (p_div_bound) else $error("test divider overrun");
endmodule : rtcc_pin_mux

/* logic/rtcc_top.sv */
`timescale 1ns/10ps
`include "rtcc_defs.svh"
module rtcc_top #(
    parameter int HALF_CYC = `RTCC_HALF_CYC
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        backup_present,
    input  wire logic        year_tick,
    input  wire logic [7:0]  year_bcd,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        alarm_irq_enable_wr,
    input  wire logic        alarm_irq_enable_in,
    input  wire logic        square_wave_enable_wr,
    input  wire logic        square_wave_enable_in,
    input  wire logic        alarm_backup_enable_wr,
    input  wire logic        alarm_backup_enable_in,
    input  wire logic        halt_oscillator_wr,
    input  wire logic        halt_oscillator_in,
    input  wire logic        power_loss_clear,
    input  wire logic        wdog_wr,
    input  wire logic [6:0]  wdog_in,
    input  wire logic        alarm_flag,
    input  wire logic        wdog_fired,
    output logic             century_toggle_enable,
    output logic             century_flag,
    output logic             pin_level_bit,
    output logic             freq_test_bit,
    output logic             alarm_irq_enable,
    output logic             square_wave_enable,
    output logic             alarm_backup_enable,
    output logic             halt_oscillator_bit,
    output logic             power_loss_marker,
    output logic [6:0]       wdog_reg,
    output logic             multi_function_pin_o,
    output logic             multi_function_pin_oe
);
    logic cen_reg, cflag_reg, level_reg, ftest_reg, aie_reg, sqw_reg, abe_reg;
    logic halt_reg, mark_reg;
    logic [`RTCC_WDOG_W-1:0] wdog_q_reg;
    logic                    rst_d_reg;
    rtcc_pkg::rtcc_pwr_type  pwr;
    logic                    century_turn;
    rtcc_pin_if              pif ();

    // host byte write aimed at one address this cycle
    function automatic logic addr_hit(input logic en, input logic [7:0] a, input logic [7:0] t);
        return en && (a == t);
    endfunction : addr_hit

    // power-up kind: first clock after release of reset
    always_ff @(posedge clock) begin
        rst_d_reg <= resetn;
    end
    always_comb begin
        if (resetn && !rst_d_reg)
            pwr = backup_present ? rtcc_pkg::RTCC_PWR_BACKUP : rtcc_pkg::RTCC_PWR_INITIAL;
        else
            pwr = rtcc_pkg::RTCC_PWR_RUN;
    end

    // century turn on year rollover 99 to 00
    assign century_turn = year_tick && (year_bcd == `RTCC_YEAR_LAST);

    // century bits at address 03h
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cen_reg   <= 1'b0; // any value allowed, zero chosen
            cflag_reg <= 1'b0;
        end else if (addr_hit(wr_en, wr_addr, `RTCC_HOURS_ADDR)) begin
            cen_reg   <= wr_data[`RTCC_CEN_BIT];
            cflag_reg <= wr_data[`RTCC_CFLAG_BIT];
        end else if (century_turn && cen_reg) begin
            cflag_reg <= ~cflag_reg;
        end
        // enable clear: flag holds
    end

    // control register 08h: level and test bits
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (!backup_present) begin
                level_reg <= 1'b1; // battery-backed: only a cold start sets it
            end
            ftest_reg <= 1'b0;
        end else if (pwr == rtcc_pkg::RTCC_PWR_INITIAL) begin
            level_reg <= 1'b1;
            ftest_reg <= 1'b0;
        end else if (pwr == rtcc_pkg::RTCC_PWR_BACKUP) begin
            ftest_reg <= 1'b0; // level kept
        end else if (addr_hit(wr_en, wr_addr, `RTCC_CTRL_ADDR)) begin
            level_reg <= wr_data[`RTCC_LEVEL_BIT];
            ftest_reg <= wr_data[`RTCC_FTEST_BIT];
        end
    end

    // alarm, square wave, backup-alarm enables
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (!backup_present) begin // kept through a backup power-up
                aie_reg <= 1'b0;
                sqw_reg <= 1'b0;
                abe_reg <= 1'b0;
            end
        end else if (pwr == rtcc_pkg::RTCC_PWR_INITIAL) begin
            aie_reg <= 1'b0;
            sqw_reg <= 1'b0;
            abe_reg <= 1'b0;
        end else if (pwr == rtcc_pkg::RTCC_PWR_RUN) begin
            if (alarm_irq_enable_wr)    aie_reg <= alarm_irq_enable_in;
            if (square_wave_enable_wr)  sqw_reg <= square_wave_enable_in;
            if (alarm_backup_enable_wr) abe_reg <= alarm_backup_enable_in;
        end
    end

    // halt bit and power-loss marker
    always_ff @(posedge clock) begin
        if (!resetn) begin
            if (!backup_present) begin
                halt_reg <= 1'b1; // kept through a backup power-up
            end
            mark_reg <= 1'b1;
        end else if (pwr == rtcc_pkg::RTCC_PWR_INITIAL) begin
            halt_reg <= 1'b1;
            mark_reg <= 1'b1;
        end else if (pwr == rtcc_pkg::RTCC_PWR_BACKUP) begin
            mark_reg <= 1'b1; // halt kept
        end else begin
            if (halt_oscillator_wr) halt_reg <= halt_oscillator_in;
            if (power_loss_clear)   mark_reg <= 1'b0;
        end
    end

    // watchdog register: multiplier and resolution
    always_ff @(posedge clock) begin
        if (!resetn || pwr != rtcc_pkg::RTCC_PWR_RUN) begin
            wdog_q_reg <= `RTCC_WDOG_ZERO;
        end else if (wdog_wr) begin
            wdog_q_reg <= wdog_in;
        end
    end

    // connect pin selector
    assign pif.level_bit          = level_reg;
    assign pif.ftest_bit          = ftest_reg;
    assign pif.alarm_irq_enable   = aie_reg;
    assign pif.square_wave_enable = sqw_reg;
    assign pif.alarm_flag         = alarm_flag;
    assign pif.wdog_nonzero       = (wdog_q_reg != `RTCC_WDOG_ZERO);
    assign pif.wdog_fired         = wdog_fired;
    assign pif.osc_running        = ~halt_reg;

    rtcc_pin_mux #(
        .HALF_CYC (HALF_CYC)
    ) u_pin (
        .clock  (clock),
        .resetn (resetn),
        .pif    (pif)
    );

    // open drain: drive low only, never high
    assign multi_function_pin_o  = 1'b0;
    assign multi_function_pin_oe = pif.pull_low;

    assign century_toggle_enable = cen_reg;
    assign century_flag          = cflag_reg;
    assign pin_level_bit         = level_reg;
    assign freq_test_bit         = ftest_reg;
    assign alarm_irq_enable      = aie_reg;
    assign square_wave_enable    = sqw_reg;
    assign alarm_backup_enable   = abe_reg;
    assign halt_oscillator_bit   = halt_reg;
    assign power_loss_marker     = mark_reg;
    assign wdog_reg              = wdog_q_reg;

    property p_toggle;
        @(posedge clock) disable iff (!resetn)
        (century_turn && cen_reg && !addr_hit(wr_en, wr_addr, `RTCC_HOURS_ADDR))
            |=> (cflag_reg != $past(cflag_reg));
    endproperty
    a_toggle: assert property (p_toggle) else $error("century flag did not invert");

    property p_hold;
        @(posedge clock) disable iff (!resetn)
        (!cen_reg && !addr_hit(wr_en, wr_addr, `RTCC_HOURS_ADDR)) |=> $stable(cflag_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("century flag changed");

    property p_init;
        @(posedge clock) disable iff (!resetn)
        (pwr == rtcc_pkg::RTCC_PWR_INITIAL) |=> (halt_reg && level_reg && mark_reg &&
            !ftest_reg && !aie_reg && !sqw_reg && !abe_reg && wdog_q_reg == `RTCC_WDOG_ZERO);
    endproperty
    a_init: assert property (p_init) else $error("initial defaults wrong");

    property p_backup;
        @(posedge clock) disable iff (!resetn)
        (pwr == rtcc_pkg::RTCC_PWR_BACKUP) |=> (mark_reg && !ftest_reg &&
            wdog_q_reg == `RTCC_WDOG_ZERO && $stable(level_reg) && $stable(aie_reg));
    endproperty
    a_backup: assert property (p_backup) else $error("backup defaults wrong");

    property p_od;
        @(posedge clock) disable iff (!resetn)
        multi_function_pin_oe |-> !multi_function_pin_o;
    endproperty
    a_od: assert property (p_od) else $error("pin driven high");

    // battery-backed bits ride through a backup power-up untouched
    sequence s_backup_hold;
        !resetn && backup_present;
    endsequence
    sequence s_retained_stable;
        $stable(level_reg) && $stable(halt_reg) && $stable(aie_reg) &&
            $stable(sqw_reg) && $stable(abe_reg);
    endsequence
    property p_retain;
        @(posedge clock)
        s_backup_hold |=> s_retained_stable;
    endproperty
    a_retain: assert property (p_retain) else $error("backed-up bits lost");
endmodule : rtcc_top

/* dv/rtcc_pull_model.sv */
`timescale 1ns/10ps
// host board side of the shared pin: a pull-up sets the released level
module rtcc_pull_model (
    input  wire logic o,
    input  wire logic oe,
    output logic      pin
);
    // device only sinks, the resistor lifts the line otherwise
    assign pin = oe ? o : 1'b1;
endmodule : rtcc_pull_model

/* dv/rtcc_century_outpin_defaults_tb_top.sv */
`timescale 1ns/10ps
module rtcc_century_outpin_defaults_tb_top;
    localparam int HC = 4;
    logic       clock = 1'b0;
    logic       resetn, backup_present, year_tick, wr_en, alarm_flag, wdog_fired, mf_pin;
    logic [7:0] year_bcd, wr_addr, wr_data;
    logic [5:0] stb;
    logic [3:0] val;
    logic [6:0] wdog_in, wdog_reg;
    logic       century_toggle_enable, century_flag, pin_level_bit, freq_test_bit;
    logic       alarm_irq_enable, square_wave_enable, alarm_backup_enable;
    logic       halt_oscillator_bit, power_loss_marker, pin_o, pin_oe;
    int         failures = 0;
    int         num_checks = 0;
    int         tg;

    // 50 MHz clock
    always #10 clock = ~clock;

    rtcc_top #(.HALF_CYC(HC)) dut (
        .clock, .resetn, .backup_present, .year_tick, .year_bcd, .wr_en, .wr_addr, .wr_data,
        .alarm_irq_enable_wr(stb[0]), .alarm_irq_enable_in(val[0]),
        .square_wave_enable_wr(stb[1]), .square_wave_enable_in(val[1]),
        .alarm_backup_enable_wr(stb[2]), .alarm_backup_enable_in(val[2]),
        .halt_oscillator_wr(stb[3]), .halt_oscillator_in(val[3]),
        .power_loss_clear(stb[4]), .wdog_wr(stb[5]), .wdog_in, .alarm_flag, .wdog_fired,
        .century_toggle_enable, .century_flag, .pin_level_bit, .freq_test_bit,
        .alarm_irq_enable, .square_wave_enable, .alarm_backup_enable,
        .halt_oscillator_bit, .power_loss_marker, .wdog_reg,
        .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe)
    );
    rtcc_pull_model host (.o(pin_o), .oe(pin_oe), .pin(mf_pin));

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic st(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : st

    // one host byte write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    // single bit strobes, index 5 loads the watchdog
    task automatic pulse(input int i, input logic [6:0] v);
        @(posedge clock);
        stb[i] <= 1'b1;
        if (i == 5) begin
            wdog_in <= v;
        end else if (i < 4) begin
            val[i] <= v[0];
        end
        @(posedge clock);
        stb <= 6'h00;
    endtask : pulse

    task automatic tick(input logic [7:0] y);
        @(posedge clock);
        year_tick <= 1'b1;
        year_bcd <= y;
        @(posedge clock);
        year_tick <= 1'b0;
    endtask : tick

    task automatic pwr(input logic bk);
        @(posedge clock);
        resetn <= 1'b0;
        backup_present <= bk;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        st(3);
    endtask : pwr

    // counts pin edges over n cycles
    task automatic cnt(input int n);
        logic p;
        tg = 0;
        p = mf_pin;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (mf_pin !== p) tg++;
            p = mf_pin;
        end
    endtask : cnt

    task automatic init_chk;
        chk(halt_oscillator_bit, 1, "halt");
        chk(pin_level_bit, 1, "level");
        chk(power_loss_marker, 1, "marker");
        chk(wdog_reg, 0, "wdog");
        chk(alarm_irq_enable, 0, "aie");
        chk(alarm_backup_enable, 0, "abe");
        chk(square_wave_enable, 0, "sqw");
        chk(freq_test_bit, 0, "ftest");
    endtask : init_chk

    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // hang guard
    initial begin
        #200000;
        failures++;
        $display("[FAIL] %0t timeout", $time);
        results();
    end

    // main sequence
    initial begin
        resetn = 0; backup_present = 0; year_tick = 0; year_bcd = 0; wr_en = 0;
        wr_addr = 0; wr_data = 0; stb = 0; val = 0; wdog_in = 0;
        alarm_flag = 0; wdog_fired = 0;
        pwr(1'b0);
        init_chk();
        chk(mf_pin, 1, "pin idle high");
        wr(8'h08, 8'h00); st(3);
        chk(pin_level_bit, 0, "level clear");
        chk(mf_pin, 0, "pin low");
        chk(pin_o, 0, "sink only");
        wr(8'h08, 8'h80); st(3);
        chk(mf_pin, 1, "pin follows level");
        wr(8'h03, 8'h80); st(2);
        chk(century_toggle_enable, 1, "cen set");
        chk(century_flag, 0, "flag clear");
        tick(8'h99); st(2);
        chk(century_flag, 1, "flag toggled up");
        tick(8'h45); st(2);
        chk(century_flag, 1, "no turn mid century");
        tick(8'h99); st(2);
        chk(century_flag, 0, "flag toggled down");
        wr(8'h03, 8'h40); st(2);
        chk(century_toggle_enable, 0, "cen clear");
        chk(century_flag, 1, "flag written");
        tick(8'h99); st(2);
        chk(century_flag, 1, "flag held");
        wr(8'h08, 8'h40); st(3); cnt(32);
        chk(tg, 0, "no toggle while halted");
        pulse(3, 7'h00); st(3); cnt(64);
        chk(tg >= 64 / HC - 1 && tg <= 64 / HC + 1, 1, "test toggle rate");
        pulse(5, 7'h0e); st(3); cnt(32);
        chk(tg, 0, "test output denied");
        chk(mf_pin, 1, "watchdog idle");
        @(posedge clock); wdog_fired <= 1'b1; st(3);
        chk(mf_pin, 0, "watchdog fired");
        @(posedge clock); wdog_fired <= 1'b0;
        pulse(5, 7'h00); wr(8'h08, 8'h80); st(3);
        chk(mf_pin, 1, "back to level");
        pulse(0, 7'h01); @(posedge clock); alarm_flag <= 1'b1; st(3);
        chk(mf_pin, 0, "alarm irq");
        pulse(1, 7'h01); st(3);
        chk(mf_pin, 1, "sqw blocks irq");
        pulse(2, 7'h01); wr(8'h08, 8'h40); pulse(5, 7'h0e); pulse(4, 7'h00); st(3);
        chk(power_loss_marker, 0, "marker cleared");
        chk(alarm_backup_enable, 1, "abe set");
        pwr(1'b1);
        chk(power_loss_marker, 1, "bk marker");
        chk(freq_test_bit, 0, "bk ftest");
        chk(wdog_reg, 0, "bk wdog");
        chk(halt_oscillator_bit, 0, "bk halt kept");
        chk(pin_level_bit, 0, "bk level kept");
        chk(alarm_irq_enable, 1, "bk aie kept");
        chk(square_wave_enable, 1, "bk sqw kept");
        chk(alarm_backup_enable, 1, "bk abe kept");
        @(posedge clock); alarm_flag <= 1'b0;
        pwr(1'b0);
        init_chk();
        results();
    end
endmodule : rtcc_century_outpin_defaults_tb_top
